/* File: rtl/tscs_frame_cnt.sv */
// bit / timeslot / frame position counter of the transmit frame
// assumes adv and align are one-cycle pulses on clk
`timescale 1ns/10ps
`default_nettype none
module tscs_frame_cnt
  import tscs_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic e1_mode,
  input wire logic adv,
  input wire logic align,
  input wire logic align_mf,
  output logic fbit,
  output logic [2:0] bit_pos,
  output logic [4:0] ts,
  output logic [3:0] frame
);
  logic fbit_reg, fbit_next;
  logic [2:0] bit_reg, bit_next;
  logic [4:0] ts_reg, ts_next;
  logic [3:0] fr_reg, fr_next;
  logic [4:0] last_ts;
  logic [3:0] last_fr;
  always_comb begin
    last_ts = e1_mode ? TSCS_E1_LAST_TS : TSCS_T1_LAST_TS;
    last_fr = e1_mode ? TSCS_E1_LAST_FR : TSCS_T1_LAST_FR;
    fbit_next = fbit_reg;
    bit_next = bit_reg;
    ts_next = ts_reg;
    fr_next = fr_reg;
    if (align) begin
      // t1 frames open with the framing bit, e1 frames with timeslot 0
      fbit_next = !e1_mode;
      bit_next = '0;
      ts_next = '0;
      if (align_mf) begin
        fr_next = '0;
      end
    end else if (adv) begin
      if (fbit_reg) begin
        fbit_next = 1'b0;
      end else if (bit_reg == TSCS_LSB_POS) begin
        bit_next = '0;
        if (ts_reg >= last_ts) begin
          ts_next = '0;
          fbit_next = !e1_mode;
          fr_next = (fr_reg >= last_fr) ? 4'h0 : fr_reg + 4'h1;
        end else begin
          ts_next = ts_reg + 5'h01;
        end
      end else begin
        bit_next = bit_reg + 3'h1;
      end
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fbit_reg <= 1'b1;
      bit_reg <= '0;
      ts_reg <= '0;
      fr_reg <= '0;
    end else begin
      fbit_reg <= fbit_next;
      bit_reg <= bit_next;
      ts_reg <= ts_next;
      fr_reg <= fr_next;
    end
  end
  assign fbit = fbit_reg;
  assign bit_pos = bit_reg;
  assign ts = ts_reg;
  assign frame = fr_reg;
endmodule : tscs_frame_cnt
`default_nettype wire

/* File: rtl/tscs_pkg.sv */
// transmit sync/channel timing package: register map, fields, reset values
// assumes a 20 MHz core clock and 32-bit Avalon-MM register access
package tscs_pkg;
  // ****************************************
  // register map (byte offsets)
  // ****************************************
  localparam logic [3:0] TSCS_CTRL_OFS = 4'h0;
  localparam logic [3:0] TSCS_STAT_OFS = 4'h4;
  localparam logic [3:0] TSCS_BLK_OFS = 4'h8;
  localparam logic [3:0] TSCS_REFDIV_OFS = 4'hC;
  // ****************************************
  // control fields
  // ****************************************
  localparam int TSCS_E1_BIT = 0;
  localparam int TSCS_ES_BIT = 1;
  localparam int TSCS_FS_OUT_BIT = 2;
  localparam int TSCS_FS_MF_BIT = 3;
  localparam int TSCS_FS_DBL_BIT = 4;
  localparam int TSCS_SS_OUT_BIT = 5;
  localparam int TSCS_SIG_EN_BIT = 6;
  localparam int TSCS_GATED_BIT = 7;
  localparam logic [7:0] TSCS_CTRL_RST = 8'h00;
  localparam logic [31:0] TSCS_BLK_RST = 32'h0000_0000;
  // ****************************************
  // frame geometry
  // ****************************************
  localparam logic [4:0] TSCS_T1_LAST_TS = 5'h17;
  localparam logic [4:0] TSCS_E1_LAST_TS = 5'h1F;
  localparam logic [3:0] TSCS_T1_LAST_FR = 4'hB;
  localparam logic [3:0] TSCS_E1_LAST_FR = 4'hF;
  localparam logic [3:0] TSCS_T1_SIG_FR_A = 4'h5;
  localparam logic [3:0] TSCS_T1_SIG_FR_B = 4'hB;
  localparam logic [2:0] TSCS_LSB_POS = 3'h7;
  // ref clock edges per 8 kHz frame: 2048 kHz / 8 kHz
  localparam int TSCS_REF_KHZ = 2048;
  localparam int TSCS_FRAME_KHZ = 8;
  localparam logic [11:0] TSCS_REFDIV_RST = 12'(TSCS_REF_KHZ / TSCS_FRAME_KHZ);
endpackage : tscs_pkg

/* File: rtl/tscs_sync.sv */
// two-flop synchroniser bank with rise/fall pulses
// assumes inputs are asynchronous to clk and much slower than it
`timescale 1ns/10ps
`default_nettype none
module tscs_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end else begin
      s1_reg <= d;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end
  assign q = s2_reg;
  assign rise = s2_reg & ~s3_reg;
  assign fall = ~s2_reg & s3_reg;
endmodule : tscs_sync
`default_nettype wire

/* File: rtl/tscs_top.sv */
// transmit sync, signaling sample and channel block/clock pins
// assumes link clocks are far slower than core_clk (sampled, not used as clocks)
`timescale 1ns/10ps
`default_nettype none
module tscs_top
  import tscs_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic tx_line_clock,
  input wire logic tx_backplane_clock,
  input wire logic backplane_ref_clock,
  input wire logic tx_frame_sync_in,
  output logic tx_frame_sync_out,
  output logic tx_frame_sync_oe,
  input wire logic tx_system_sync_in,
  output logic tx_system_sync_out,
  output logic tx_system_sync_oe,
  input wire logic tx_signaling_in,
  output logic sig_bit,
  output logic sig_strobe,
  output logic tx_channel_block,
  output logic tx_channel_clock
);
  // ****************************************
  // pin synchronisers
  // ****************************************
  // order: sig, ssync, fsync, ref, bp, line
  logic [5:0] pin_q, pin_rise, pin_fall;
  tscs_sync #(.W(6)) u_sync (
    .clk(core_clk),
    .rst_n(rst_n),
    .d({tx_signaling_in, tx_system_sync_in, tx_frame_sync_in,
        backplane_ref_clock, tx_backplane_clock, tx_line_clock}),
    .q(pin_q),
    .rise(pin_rise),
    .fall(pin_fall)
  );
  logic line_r, bp_r, ref_r, act_r, act_f, act_q;
  logic [7:0] ctrl_reg, ctrl_next;
  logic es_on, e1_on;
  assign es_on = ctrl_reg[TSCS_ES_BIT];
  assign e1_on = ctrl_reg[TSCS_E1_BIT];
  assign line_r = pin_rise[0];
  assign bp_r = pin_rise[1];
  assign ref_r = pin_rise[2];
  // elastic store selects which clock paces the frame
  assign act_r = es_on ? bp_r : line_r;
  assign act_f = es_on ? pin_fall[1] : pin_fall[0];
  assign act_q = es_on ? pin_q[1] : pin_q[0];
  // ****************************************
  // register slave
  // ****************************************
  logic [31:0] blk_reg, blk_next;
  logic [11:0] refdiv_reg, refdiv_next;
  logic wait_reg, wait_next;
  logic [31:0] rdata_reg, rdata_next;
  logic req, wr_now;
  logic fbit;
  logic [2:0] bit_pos;
  logic [4:0] ts;
  logic [3:0] frame;
  assign req = avs_read | avs_write;
  // a write lands on the single cycle waitrequest is low
  assign wr_now = avs_write & !wait_reg;
  always_comb begin
    ctrl_next = ctrl_reg;
    blk_next = blk_reg;
    refdiv_next = refdiv_reg;
    wait_next = !(req && wait_reg);
    rdata_next = rdata_reg;
    if (wr_now) begin
      case (avs_address)
        TSCS_CTRL_OFS: ctrl_next = avs_writedata[7:0];
        TSCS_BLK_OFS: blk_next = avs_writedata;
        TSCS_REFDIV_OFS: refdiv_next = avs_writedata[11:0];
        default: ctrl_next = ctrl_reg;
      endcase
    end
    if (avs_read && wait_reg) begin
      case (avs_address)
        TSCS_CTRL_OFS: rdata_next = {24'h000000, ctrl_reg};
        TSCS_STAT_OFS: rdata_next = {16'h0000, frame, fbit, bit_pos, ts, act_q, 2'h0};
        TSCS_BLK_OFS: rdata_next = blk_reg;
        TSCS_REFDIV_OFS: rdata_next = {20'h00000, refdiv_reg};
        default: rdata_next = 32'h0000_0000;
      endcase
    end
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= TSCS_CTRL_RST;
      blk_reg <= TSCS_BLK_RST;
      refdiv_reg <= TSCS_REFDIV_RST;
      wait_reg <= 1'b1;
      rdata_reg <= 32'h0000_0000;
    end else begin
      ctrl_reg <= ctrl_next;
      blk_reg <= blk_next;
      refdiv_reg <= refdiv_next;
      wait_reg <= wait_next;
      rdata_reg <= rdata_next;
    end
  end
  assign avs_waitrequest = wait_reg;
  assign avs_readdata = rdata_reg;
  // ****************************************
  // frame position
  // ****************************************
  logic fs_in_pulse, ss_in_pulse, align;
  logic fs_seen_reg, fs_seen_next, ss_seen_reg, ss_seen_next;
  // sync pins are taken as levels at the pacing clock's rise, so a pulse launched
  // on the falling edge is seen; a pin held high aligns the frame only once
  always_comb begin
    fs_seen_next = line_r ? pin_q[3] : fs_seen_reg;
    ss_seen_next = bp_r ? pin_q[4] : ss_seen_reg;
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      fs_seen_reg <= 1'b0;
      ss_seen_reg <= 1'b0;
    end else begin
      fs_seen_reg <= fs_seen_next;
      ss_seen_reg <= ss_seen_next;
    end
  end
  // frame sync input is honoured only while its pin is an input
  assign fs_in_pulse = !ctrl_reg[TSCS_FS_OUT_BIT] && !es_on && line_r && pin_q[3]
      && !fs_seen_reg;
  // system sync input ignored without elastic store, far side holds it low
  assign ss_in_pulse = !ctrl_reg[TSCS_SS_OUT_BIT] && es_on && bp_r && pin_q[4]
      && !ss_seen_reg;
  assign align = fs_in_pulse | ss_in_pulse;
  tscs_frame_cnt u_cnt (
    .clk(core_clk),
    .rst_n(rst_n),
    .e1_mode(e1_on),
    .adv(act_r),
    .align(align),
    .align_mf(ctrl_reg[TSCS_FS_MF_BIT]),
    .fbit(fbit),
    .bit_pos(bit_pos),
    .ts(ts),
    .frame(frame)
  );
  // ****************************************
  // sync outputs
  // ****************************************
  logic fs_out_reg, fs_out_next, fs_oe_reg, ss_oe_reg;
  logic ss_out_reg, ss_out_next;
  logic [11:0] ref_cnt_reg, ref_cnt_next;
  logic fr_start, fr_second, sig_frame;
  assign fr_start = e1_on ? (!fbit && ts == 5'h00 && bit_pos == 3'h0) : fbit;
  assign fr_second = !e1_on && !fbit && ts == 5'h00 && bit_pos == 3'h0;
  assign sig_frame = frame == TSCS_T1_SIG_FR_A || frame == TSCS_T1_SIG_FR_B;
  always_comb begin
    fs_out_next = fs_out_reg;
    ss_out_next = ss_out_reg;
    ref_cnt_next = ref_cnt_reg;
    if (line_r) begin
      if (ctrl_reg[TSCS_FS_MF_BIT]) begin
        fs_out_next = fr_start && frame == 4'h0;
      end else begin
        fs_out_next = fr_start ||
          (ctrl_reg[TSCS_FS_DBL_BIT] && fr_second && sig_frame);
      end
    end
    if (ref_r) begin
      // one reference period high once per frame period
      ref_cnt_next = (ref_cnt_reg >= refdiv_reg - 12'h001) ? 12'h000 : ref_cnt_reg + 12'h001;
      ss_out_next = ref_cnt_reg == 12'h000;
    end
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      fs_out_reg <= 1'b0;
      ss_out_reg <= 1'b0;
      ref_cnt_reg <= 12'h000;
      fs_oe_reg <= 1'b0;
      ss_oe_reg <= 1'b0;
    end else begin
      fs_out_reg <= fs_out_next;
      ss_out_reg <= ss_out_next;
      ref_cnt_reg <= ref_cnt_next;
      fs_oe_reg <= ctrl_reg[TSCS_FS_OUT_BIT];
      ss_oe_reg <= ctrl_reg[TSCS_SS_OUT_BIT];
    end
  end
  assign tx_frame_sync_out = fs_out_reg;
  assign tx_frame_sync_oe = fs_oe_reg;
  assign tx_system_sync_out = ss_out_reg;
  assign tx_system_sync_oe = ss_oe_reg;
  // ****************************************
  // signaling sample, channel block and clock
  // ****************************************
  logic sig_bit_reg, sig_bit_next, sig_stb_reg, sig_stb_next;
  logic blk_out_reg, blk_out_next, chclk_reg, chclk_next, blk_lvl;
  assign blk_lvl = !fbit && blk_reg[ts];
  always_comb begin
    sig_bit_next = sig_bit_reg;
    sig_stb_next = 1'b0;
    blk_out_next = blk_out_reg;
    chclk_next = chclk_reg;
    if (ctrl_reg[TSCS_SIG_EN_BIT] && act_f) begin
      sig_bit_next = pin_q[5];
      sig_stb_next = 1'b1;
    end
    if (act_r) begin
      blk_out_next = blk_lvl;
    end
    // gated mode follows the sampled clock level, so it lags the pin by the sync delay
    if (ctrl_reg[TSCS_GATED_BIT]) begin
      chclk_next = act_q && blk_out_reg;
    end else if (act_r) begin
      chclk_next = !fbit && bit_pos == TSCS_LSB_POS;
    end
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sig_bit_reg <= 1'b0;
      sig_stb_reg <= 1'b0;
      blk_out_reg <= 1'b0;
      chclk_reg <= 1'b0;
    end else begin
      sig_bit_reg <= sig_bit_next;
      sig_stb_reg <= sig_stb_next;
      blk_out_reg <= blk_out_next;
      chclk_reg <= chclk_next;
    end
  end
  assign sig_bit = sig_bit_reg;
  assign sig_strobe = sig_stb_reg;
  assign tx_channel_block = blk_out_reg;
  assign tx_channel_clock = chclk_reg;
  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence bus_req_s;
    req && wait_reg;
  endsequence
  sequence bus_ack_s;
    !wait_reg ##1 wait_reg;
  endsequence
  bus_answer_a: assert property (bus_req_s |=> bus_ack_s)
    else $error("bus answer not one cycle after request");
  ctrl_write_a: assert property (avs_write && !wait_reg && avs_address == TSCS_CTRL_OFS
      |=> ctrl_reg == $past(avs_writedata[7:0]))
    else $error("control write lost");
  fs_dir_a: assert property (##1 tx_frame_sync_oe == $past(ctrl_reg[TSCS_FS_OUT_BIT]))
    else $error("frame sync direction wrong");
  fs_line_a: assert property (!$past(line_r) |-> $stable(tx_frame_sync_out))
    else $error("frame sync moved off line clock");
  ss_ignored_a: assert property (!es_on && act_r && !fs_in_pulse && !fbit
      && bit_pos != TSCS_LSB_POS |=> bit_pos == $past(bit_pos) + 3'h1)
    else $error("frame moved without elastic store");
  align_start_a: assert property (align |=> bit_pos == 3'h0 && ts == 5'h00)
    else $error("sync pulse did not align the frame");
  fs_wide_a: assert property (line_r && !e1_on && !ctrl_reg[TSCS_FS_MF_BIT]
      && ctrl_reg[TSCS_FS_DBL_BIT] && fr_second && sig_frame |=> tx_frame_sync_out)
    else $error("double wide frame pulse missing");
  gated_low_a: assert property (ctrl_reg[TSCS_GATED_BIT] && $past(ctrl_reg[TSCS_GATED_BIT])
      && !$past(tx_channel_block) |-> !tx_channel_clock)
    else $error("gated channel clock leaked");
  blk_line_a: assert property (!es_on && !$past(line_r) && !$past(es_on)
      |-> $stable(tx_channel_block))
    else $error("channel block moved off line clock");
  chclk_lsb_a: assert property (act_r && !ctrl_reg[TSCS_GATED_BIT] && !fbit
      && bit_pos == TSCS_LSB_POS |=> tx_channel_clock)
    else $error("channel clock missed lsb");
  sig_sample_a: assert property (sig_strobe |-> $past(act_f) && $past(ctrl_reg[TSCS_SIG_EN_BIT]))
    else $error("signaling sampled off falling edge");
  ref_pulse_a: assert property (ref_r && ref_cnt_reg == 12'h000 |=> tx_system_sync_out)
    else $error("8 kHz pulse missing");
endmodule : tscs_top
`default_nettype wire

/* File: testbench/tb.sv */
// self-checking bench for the transmit sync and channel timing block
// assumes the partner model supplies all link clocks at 400 ns
`timescale 1ns/10ps
`default_nettype none
module tb;
  import tscs_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  wire lclk, bclk, rclk, fs_in, ss_in, sig_in;
  logic fs_out, fs_oe, ss_out, ss_oe, sig_bit, sig_strobe, ch_blk, ch_clk;
  logic use_bp = 1'b0;
  logic fs_go = 1'b0;
  logic ss_go = 1'b0;
  logic sig_on = 1'b0;
  logic q_sig[$];
  logic [31:0] rd;
  logic [31:0] blk;
  integer seed = 62717;
  integer err_total = 0;
  integer num_checks = 0;
  integer n_strobe = 0;
  integer a, b, c, g, bits, k;
  int ctl[5] = '{8'h04, 8'h05, 8'h14, 8'h0C, 8'h84};
  int fr[5] = '{2, 2, 12, 12, 2};
  int efs[5] = '{2, 2, 14, 1, 2};
  always #25 core_clk = ~core_clk;
  tscs_partner far_end (.use_bp(use_bp), .fs_go(fs_go), .ss_go(ss_go), .tx_line_clock(lclk),
    .tx_backplane_clock(bclk),
    .backplane_ref_clock(rclk), .tx_frame_sync_in(fs_in), .tx_system_sync_in(ss_in),
    .tx_signaling_in(sig_in));
  tscs_top dut (.core_clk(core_clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .tx_line_clock(lclk),
    .tx_backplane_clock(bclk), .backplane_ref_clock(rclk), .tx_frame_sync_in(fs_in),
    .tx_frame_sync_out(fs_out), .tx_frame_sync_oe(fs_oe), .tx_system_sync_in(ss_in),
    .tx_system_sync_out(ss_out), .tx_system_sync_oe(ss_oe), .tx_signaling_in(sig_in),
    .sig_bit(sig_bit), .sig_strobe(sig_strobe), .tx_channel_block(ch_blk),
    .tx_channel_clock(ch_clk));
  // ****************************************
  // checking and bus tasks
  // ****************************************
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic bus(input logic wr, input logic [3:0] adr, input logic [31:0] d);
    integer n;
    n = 0;
    @(posedge core_clk);
    avs_address <= adr;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= d;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (avs_waitrequest !== 1'b0) begin
      err_total++;
      tally_and_finish();
    end
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  // outputs settle ~3 core cycles after a line rise, so sample at the next rise;
  // the falling-edge sample sees the high half of the gated bit clock
  task automatic run_bits(input integer n);
    a = 0;
    b = 0;
    c = 0;
    g = 0;
    repeat (n) begin
      @(posedge lclk);
      a += (fs_out === 1'b1);
      b += (ch_clk === 1'b1);
      c += (ch_blk === 1'b1);
      @(negedge lclk);
      g += (ch_clk === 1'b1);
    end
  endtask : run_bits
  // ****************************************
  // signaling reference model
  // ****************************************
  always @(negedge lclk) if (sig_on && !use_bp) q_sig.push_back(sig_in);
  always @(negedge bclk) if (sig_on && use_bp) q_sig.push_back(sig_in);
  always @(posedge core_clk) begin
    if (sig_on && sig_strobe === 1'b1) begin
      n_strobe++;
      if (q_sig.size() == 0) chk("signaling strobe", 32'h0, 32'h1);
      else chk("signaling bit", {31'h0, q_sig.pop_front()}, {31'h0, sig_bit});
    end
  end
  initial begin
    #4500000;
    err_total++;
    tally_and_finish();
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    bus(0, TSCS_CTRL_OFS, 32'h0);
    chk("ctrl reset", 32'(TSCS_CTRL_RST), rd);
    bus(0, TSCS_BLK_OFS, 32'h0);
    chk("block reset", TSCS_BLK_RST, rd);
    bus(0, TSCS_REFDIV_OFS, 32'h0);
    chk("refdiv reset", 32'(TSCS_REFDIV_RST), rd);
    bus(0, 4'h2, 32'h0);
    chk("unmapped read", 32'h0, rd);
    bus(0, TSCS_STAT_OFS, 32'h0);
    chk("status spare bits", 32'h0, rd & 32'hFFFF_0003);
    $display("test registers done");
    for (int i = 0; i < 5; i++) begin
      blk = $random(seed);
      bus(1, TSCS_BLK_OFS, blk);
      bus(0, TSCS_BLK_OFS, 32'h0);
      chk("block readback", blk, rd);
      bus(1, TSCS_CTRL_OFS, {24'h0, ctl[i][7:0]});
      bits = ctl[i][0] ? 256 : 193;
      if (!ctl[i][0]) blk[31:24] = 8'h00;
      run_bits(200);
      run_bits(fr[i] * bits);
      chk("frame sync pulses", efs[i], a);
      chk("channel clock", ctl[i][7] ? 0 : fr[i] * (bits / 8), b);
      chk("gated clock", ctl[i][7] ? fr[i] * 8 * $countones(blk) : fr[i] * (bits / 8), g);
      chk("channel block", fr[i] * 8 * $countones(blk), c);
      chk("frame sync oe", 32'h1, {31'h0, fs_oe});
      $display("test timing %0d done", i);
    end
    bus(1, TSCS_REFDIV_OFS, 32'h10);
    bus(1, TSCS_CTRL_OFS, 32'h20);
    repeat (40) @(posedge rclk);
    a = 0;
    repeat (48) begin
      @(posedge rclk);
      a += (ss_out === 1'b1);
    end
    chk("system sync pulses", 32'h3, a);
    chk("system sync oe", 32'h1, {31'h0, ss_oe});
    chk("frame sync oe off", 32'h0, {31'h0, fs_oe});
    $display("test system sync done");
    // a sync pulse aligns the frame; its frame pulse shows at the second line rise after
    for (int m = 0; m < 3; m++) begin
      bus(1, TSCS_CTRL_OFS, m == 2 ? 32'h02 : (m == 1 ? 32'h08 : 32'h00));
      repeat (2) begin
        repeat (100) @(posedge lclk);
        if (m == 2) begin
          @(posedge bclk) ss_go <= 1'b1;
          @(posedge bclk) ss_go <= 1'b0;
        end else begin
          @(posedge lclk) fs_go <= 1'b1;
          @(posedge lclk) fs_go <= 1'b0;
        end
        a = 0;
        for (k = 0; k < 3; k++) begin
          @(posedge lclk);
          a = a * 2 + (fs_out === 1'b1);
        end
      end
      chk("sync input alignment", 32'h2, a);
      $display("test alignment %0d done", m);
    end
    for (int m = 0; m < 2; m++) begin
      use_bp = m[0];
      bus(1, TSCS_CTRL_OFS, m ? 32'h42 : 32'h40);
      repeat (4) @(posedge lclk);
      if (m) @(posedge bclk);
      else @(posedge lclk);
      q_sig.delete();
      n_strobe = 0;
      sig_on = 1'b1;
      for (k = 0; k < 4000 && n_strobe < 20; k++) @(posedge core_clk);
      chk("signaling strobes", 32'd20, n_strobe);
      if (m) @(posedge bclk);
      else @(posedge lclk);
      sig_on = 1'b0;
      $display("test signaling %0d done", m);
    end
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire

/* File: testbench/tscs_partner.sv */
// backplane-side partner: free-running link clocks, sync input pulses on request
// assumes the bench selects which clock paces the signaling stream
`timescale 1ns/10ps
`default_nettype none
module tscs_partner (
  input wire logic use_bp,
  input wire logic fs_go,
  input wire logic ss_go,
  output logic tx_line_clock,
  output logic tx_backplane_clock,
  output logic backplane_ref_clock,
  output logic tx_frame_sync_in,
  output logic tx_system_sync_in,
  output logic tx_signaling_in
);
  integer seed = 62717;
  initial begin
    tx_frame_sync_in = 1'b0;
    tx_system_sync_in = 1'b0;
    tx_signaling_in = 1'b0;
  end
  // ****************************************
  // clocks: odd phase offsets keep edges off the core clock edges
  // ****************************************
  initial begin
    tx_line_clock = 1'b0;
    #137;
    forever #200 tx_line_clock = ~tx_line_clock;
  end
  initial begin
    tx_backplane_clock = 1'b0;
    #61;
    forever #200 tx_backplane_clock = ~tx_backplane_clock;
  end
  initial begin
    backplane_ref_clock = 1'b0;
    #92;
    forever #200 backplane_ref_clock = ~backplane_ref_clock;
  end
  // sync pulses change on falling edges so they stand at the pacing clock's rise
  always @(negedge tx_line_clock) tx_frame_sync_in <= fs_go;
  always @(negedge tx_backplane_clock) tx_system_sync_in <= ss_go;
  // signaling changes only on rising edges of the active clock
  always @(posedge tx_line_clock) if (!use_bp) tx_signaling_in <= 1'($random(seed));
  always @(posedge tx_backplane_clock) if (use_bp) tx_signaling_in <= 1'($random(seed));
endmodule : tscs_partner
`default_nettype wire
